// ---- hdl/regbuf_pkg.sv ----
// Shared constants and types for the registered command/address buffer
package regbuf_pkg;

  // Data lane count; bit 0 carries input position 1
  localparam int unsigned LANES = 25;

  // Stages of every input synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // Active lane masks per topology
  localparam logic [LANES-1:0] MASK_ONE_TO_ONE = 25'h1ffffb6;
  localparam logic [LANES-1:0] MASK_PAIR_A     = 25'h0003fb6;
  localparam logic [LANES-1:0] MASK_PAIR_B     = 25'h0001bbf;

  // Link edges the error output stays low once asserted
  localparam logic [1:0] ERR_HOLD_EDGES = 2'h2;

  // Reset value of every register of the block except cross_prev_ff, which resets to its inverse
  localparam logic RESET_LEVEL = 1'b0;

  // Topologies chosen by the two configuration inputs
  typedef enum logic [1:0] {
    TOPO_ONE_TO_ONE,
    TOPO_PAIR_A,
    TOPO_PAIR_B
  } topo_e;

  // One registered copy of all outputs that face the DRAMs
  typedef struct packed {
    logic [LANES-1:0] cmd_addr;
    logic             termination;
    logic             clk_enable;
    logic             select_copy;
  } out_copy_s;

  // Synchronised image of every input pin
  typedef struct packed {
    logic             clk_p;
    logic             clk_n;
    logic             pair_position;
    logic             fanout_mode;
    logic             module_sel_n;
    logic             rank_sel_n;
    logic [LANES-1:0] cmd_addr;
    logic             termination;
    logic             clk_enable;
    logic             parity_bit;
  } pin_in_s;

  // Width of the synchronised pin bundle
  localparam int unsigned PIN_W = $bits(pin_in_s);

endpackage : regbuf_pkg

// ---- hdl/sync_bank.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous inputs
module sync_bank #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule : sync_bank

// ---- hdl/regbuf_top.sv ----
// Configurable registered command/address buffer with parity check
// What this block does
// - Capture data, termination and clock-enable where positive clock rises, negative is low.
// - Active-low reset acts asynchronously and clears every internal register except the crossing history, which it sets.
// - Both chip selects high hold gated data outputs; either low updates them.
// - Termination, clock-enable and select copy outputs update on every capture.
// - Partial parity is high when active data lanes and the parity bit hold an odd count of ones.
// - Error output is active-low open drain, one local cycle after its partial parity output.
// - Unused positions ignore their inputs and drive their outputs low.
// - Two configuration inputs pick one-to-one or pair A or pair B topology.
// - Config 00 uses positions 2,3,5,6,8-25 one to one.
// - Config 01 (pair A) uses positions 2,3,5,6,8-14.
// - Config 11 (pair B) uses positions 1-6,8-10,12,13.
// - Second input picks 25-bit or 14-bit fanout; first picks pinout A or B.
// - Even parity: error when active data plus parity bit have odd ones.
// - Partial parity appears at the capture after its data's capture; error one local cycle later.
// - Asserted error stays low for two cycles or until reset.
module regbuf_top (
  input  wire logic                             clk_i,
  input  wire logic                             rstn_i,
  input  wire logic                             diff_clock_p_i,
  input  wire logic                             diff_clock_n_i,
  input  wire logic                             pair_position_select_i,
  input  wire logic                             fanout_mode_select_i,
  input  wire logic                             module_select_n_i,
  input  wire logic                             rank_select_n_i,
  input  wire logic [regbuf_pkg::LANES-1:0]     cmd_addr_in_i,
  input  wire logic                             termination_in_i,
  input  wire logic                             clk_enable_in_i,
  input  wire logic                             parity_bit_in_i,
  output logic      [regbuf_pkg::LANES-1:0]     cmd_addr_out_a_o,
  output logic      [regbuf_pkg::LANES-1:0]     cmd_addr_out_b_o,
  output logic                                  termination_out_a_o,
  output logic                                  termination_out_b_o,
  output logic                                  clk_enable_out_a_o,
  output logic                                  clk_enable_out_b_o,
  output logic                                  select_copy_out_a_o,
  output logic                                  select_copy_out_b_o,
  output logic                                  partial_parity_out_o,
  output logic                                  parity_error_n_o,
  output logic                                  parity_error_n_oe_o
);

  // Map the two configuration inputs onto a topology
  function automatic regbuf_pkg::topo_e decode_topo(input logic pos_sel, input logic fan_sel);
    if (!fan_sel) begin
      decode_topo = regbuf_pkg::TOPO_ONE_TO_ONE;
    end else if (!pos_sel) begin
      decode_topo = regbuf_pkg::TOPO_PAIR_A;
    end else begin
      decode_topo = regbuf_pkg::TOPO_PAIR_B;
    end
  endfunction : decode_topo

  // Active lane set of a topology
  function automatic logic [regbuf_pkg::LANES-1:0] lane_mask(input regbuf_pkg::topo_e topo);
    unique case (topo)
      regbuf_pkg::TOPO_ONE_TO_ONE: lane_mask = regbuf_pkg::MASK_ONE_TO_ONE;
      regbuf_pkg::TOPO_PAIR_A:     lane_mask = regbuf_pkg::MASK_PAIR_A;
      regbuf_pkg::TOPO_PAIR_B:     lane_mask = regbuf_pkg::MASK_PAIR_B;
      default:                     lane_mask = '0;
    endcase
  endfunction : lane_mask

  regbuf_pkg::pin_in_s           pin_raw;
  regbuf_pkg::pin_in_s           pin_s;
  logic [regbuf_pkg::PIN_W-1:0]  pin_sync;
  logic [1:0]                    warm_ff;
  logic                          warm;
  logic                          crossed;
  logic                          cross_prev_ff;
  logic                          capture;
  regbuf_pkg::topo_e             topo;
  logic [regbuf_pkg::LANES-1:0]  mask;
  logic                          fanout;
  logic                          cs_active;
  logic [regbuf_pkg::LANES-1:0]  data_act;
  regbuf_pkg::out_copy_s         copy_ff;
  regbuf_pkg::out_copy_s         nxt_copy;
  logic                          data_par_ff;
  logic                          par_sum;
  logic                          ppo_ff;
  logic                          err_ff;
  logic [1:0]                    hold_ff;

  // Bundle every pin for the synchroniser
  assign pin_raw = '{
    clk_p:         diff_clock_p_i,
    clk_n:         diff_clock_n_i,
    pair_position: pair_position_select_i,
    fanout_mode:   fanout_mode_select_i,
    module_sel_n:  module_select_n_i,
    rank_sel_n:    rank_select_n_i,
    cmd_addr:      cmd_addr_in_i,
    termination:   termination_in_i,
    clk_enable:    clk_enable_in_i,
    parity_bit:    parity_bit_in_i
  };

  // All pins cross into the local clock through two flip-flops
  sync_bank #(
    .WIDTH (regbuf_pkg::PIN_W)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pin_raw),
    .sync_o  (pin_sync)
  );

  assign pin_s = regbuf_pkg::pin_in_s'(pin_sync);

  // Synchroniser fill count; the cleared stages would otherwise fake a low link clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      warm_ff <= '0;
    end else if (!warm) begin
      warm_ff <= warm_ff + 2'h1;
    end
  end

  assign warm = (warm_ff == 2'(regbuf_pkg::SYNC_STAGES));

  // Crossing of the pair: positive high while negative low, judged on one sample
  assign crossed = pin_s.clk_p & ~pin_s.clk_n;

  // Previous crossing level; held high until the stages fill so release makes no edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cross_prev_ff <= ~regbuf_pkg::RESET_LEVEL;
    end else if (!warm) begin
      cross_prev_ff <= ~regbuf_pkg::RESET_LEVEL;
    end else begin
      cross_prev_ff <= crossed;
    end
  end

  // Capture where the crossing first appears; a skewed sample of the pair only delays it
  assign capture = warm & crossed & ~cross_prev_ff;

  // Configuration decode and input masking
  assign topo      = decode_topo(pin_s.pair_position, pin_s.fanout_mode);
  assign mask      = lane_mask(topo);
  assign fanout    = (topo != regbuf_pkg::TOPO_ONE_TO_ONE);
  assign data_act  = pin_s.cmd_addr & mask;
  assign cs_active = ~(pin_s.module_sel_n & pin_s.rank_sel_n);

  // Next output copy: gated lanes hold while both selects are high
  always_comb begin
    nxt_copy             = copy_ff;
    nxt_copy.termination = pin_s.termination;
    nxt_copy.clk_enable  = pin_s.clk_enable;
    nxt_copy.select_copy = pin_s.module_sel_n;
    if (cs_active) begin
      nxt_copy.cmd_addr = data_act;
    end else begin
      nxt_copy.cmd_addr = copy_ff.cmd_addr & mask;
    end
  end

  // Output register, loaded on each link capture edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      copy_ff <= '0;
    end else if (capture) begin
      copy_ff <= nxt_copy;
    end
  end

  // Copy A always drives; copy B only in fanout mode, else low
  assign cmd_addr_out_a_o    = copy_ff.cmd_addr;
  assign termination_out_a_o = copy_ff.termination;
  assign clk_enable_out_a_o  = copy_ff.clk_enable;
  assign select_copy_out_a_o = copy_ff.select_copy;

  // B copies registered alongside A for identical timing
  regbuf_pkg::out_copy_s copy_b_ff;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      copy_b_ff <= '0;
    end else if (capture) begin
      copy_b_ff <= fanout ? nxt_copy : '0;
    end
  end

  assign cmd_addr_out_b_o    = copy_b_ff.cmd_addr;
  assign termination_out_b_o = copy_b_ff.termination;
  assign clk_enable_out_b_o  = copy_b_ff.clk_enable;
  assign select_copy_out_b_o = copy_b_ff.select_copy;

  // Parity of the lanes registered at the previous capture
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_par_ff <= regbuf_pkg::RESET_LEVEL;
    end else if (capture) begin
      data_par_ff <= ^data_act;
    end
  end

  // Parity bit captured one link cycle after its data closes the sum
  assign par_sum = data_par_ff ^ pin_s.parity_bit;

  // Partial parity output, registered at the link capture after its data's capture
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ppo_ff <= regbuf_pkg::RESET_LEVEL;
    end else if (capture) begin
      ppo_ff <= par_sum;
    end
  end

  assign partial_parity_out_o = ppo_ff;

  // Error flag with a two edge hold; a new error restarts the hold
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_ff  <= regbuf_pkg::RESET_LEVEL;
      hold_ff <= '0;
    end else if (capture) begin
      if (par_sum) begin
        err_ff  <= 1'b1;
        hold_ff <= regbuf_pkg::ERR_HOLD_EDGES - 2'h1;
      end else if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
      end else begin
        err_ff  <= 1'b0;
      end
    end
  end

  // Open drain: enable pulls low, data stays low so the pin only sinks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      parity_error_n_o    <= regbuf_pkg::RESET_LEVEL;
      parity_error_n_oe_o <= regbuf_pkg::RESET_LEVEL;
    end else begin
      parity_error_n_o    <= 1'b0;
      parity_error_n_oe_o <= err_ff;
    end
  end

endmodule : regbuf_top

// ---- tb/regbuf_asserts.sv ----
// Port assertions for the registered buffer
module regbuf_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        diff_clock_p_i,
  input wire logic        pair_position_select_i,
  input wire logic        fanout_mode_select_i,
  input wire logic        module_select_n_i,
  input wire logic        rank_select_n_i,
  input wire logic [24:0] cmd_addr_out_a_o,
  input wire logic [24:0] cmd_addr_out_b_o,
  input wire logic        partial_parity_out_o,
  input wire logic        parity_error_n_o,
  input wire logic        parity_error_n_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  p_ff;
  logic [3:0]  age_ff;
  logic [24:0] mask;
  // Active lanes of the strapped topology
  assign mask = !fanout_mode_select_i ? regbuf_pkg::MASK_ONE_TO_ONE :
                pair_position_select_i ? regbuf_pkg::MASK_PAIR_B : regbuf_pkg::MASK_PAIR_A;
  // Cycles since the synchronised link clock rose
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p_ff   <= 3'h0;
      age_ff <= 4'hf;
    end else begin
      p_ff   <= {p_ff[1:0], diff_clock_p_i};
      age_ff <= (p_ff[1] && !p_ff[2]) ? 4'h0 : age_ff + {3'h0, ~&age_ff};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence idle_s; (module_select_n_i && rank_select_n_i) [*8]; endsequence
  sequence err_s; $rose(parity_error_n_oe_o); endsequence
  a_gated_hold: assert property (idle_s |=> $stable(cmd_addr_out_a_o)) else $error("held lanes moved");
  a_capture_timed: assert property ($changed(cmd_addr_out_a_o) |-> age_ff < 4'h4) else $error("late update");
  a_lanes_masked: assert property ((cmd_addr_out_a_o & ~mask) == 25'h0) else $error("idle lane high");
  a_copy_twin: assert property (fanout_mode_select_i |-> cmd_addr_out_b_o == cmd_addr_out_a_o)
    else $error("copies differ");
  a_copy_idle: assert property (!fanout_mode_select_i |-> cmd_addr_out_b_o == 25'h0) else $error("b high");
  a_error_cause: assert property (err_s |-> $past(partial_parity_out_o)) else $error("error no cause");
  a_error_holds: assert property (err_s |-> parity_error_n_oe_o [*8]) else $error("error short");
  a_error_drain: assert property (parity_error_n_o == 1'b0) else $error("error pin high");
endmodule : regbuf_asserts

bind regbuf_top regbuf_asserts chk_u (.*);

// ---- tb/ctrl_model.sv ----
// Behavioural memory controller feeding the buffer
module ctrl_model (
  input  wire logic [24:0] mask_i,
  output logic             link_p_o,
  output logic             link_n_o,
  output logic [24:0]      cmd_o,
  output logic             term_o,
  output logic             cke_o,
  output logic [1:0]       sel_n_o,
  output logic             par_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] last;
  // Free-running differential link clock, idle pins at start
  initial begin
    last = 25'h0;
    link_p_o = 1'b0;
    send(25'h0, 2'h3, 1'b0);
    forever #62.5 link_p_o = ~link_p_o;
  end
  assign link_n_o = ~link_p_o;
  // One word, with the parity of the word before it
  task automatic send(input logic [24:0] d, input logic [1:0] sn, input logic flip);
    cmd_o   = d;
    term_o  = ~d[6];
    cke_o   = d[10];
    sel_n_o = sn;
    par_o   = ^(last & mask_i) ^ flip;
    last    = d;
  endtask : send
endmodule : ctrl_model

// ---- tb/regbuf_top_test.sv ----
// Self-checking bench for the registered buffer
module regbuf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [24:0] WORDS [0:6] = '{25'h1ffffff, 25'h0a5a5a5, 25'h1555555, 25'h0ffffff,
                                          25'h0, 25'h1abcdef, 25'h0};
  localparam logic [13:0] SELS  = 14'h306c;
  localparam logic [6:0]  FLIPS = 7'h32;
  logic        clk_i, rstn_i, c0, c1, lp, ln, term, cke, par, ta, tb, ka, kb, sa, sb, partial_parity_out, err_n, err_oe;
  logic [1:0]  sel_n, hist;
  logic [24:0] cmd, qa, qb, mask, exp_a;
  int          n_fail, checks_done;
  wire         err_line = err_oe ? err_n : 1'b1;
  // Lanes of the strapped topology
  assign mask = !c1 ? regbuf_pkg::MASK_ONE_TO_ONE : c0 ? regbuf_pkg::MASK_PAIR_B : regbuf_pkg::MASK_PAIR_A;
  // 125 MHz local clock
  always #4 clk_i = ~clk_i;
  // Controller model and design
  ctrl_model ctrl_u (.mask_i(mask), .link_p_o(lp), .link_n_o(ln), .cmd_o(cmd), .term_o(term), .cke_o(cke),
    .sel_n_o(sel_n), .par_o(par));
  regbuf_top dut_u (.clk_i, .rstn_i, .diff_clock_p_i(lp), .diff_clock_n_i(ln), .pair_position_select_i(c0),
    .fanout_mode_select_i(c1), .module_select_n_i(sel_n[1]), .rank_select_n_i(sel_n[0]), .cmd_addr_in_i(cmd),
    .termination_in_i(term), .clk_enable_in_i(cke), .parity_bit_in_i(par), .cmd_addr_out_a_o(qa),
    .cmd_addr_out_b_o(qb), .termination_out_a_o(ta), .termination_out_b_o(tb), .clk_enable_out_a_o(ka),
    .clk_enable_out_b_o(kb), .select_copy_out_a_o(sa), .select_copy_out_b_o(sb), .partial_parity_out_o(partial_parity_out),
    .parity_error_n_o(err_n), .parity_error_n_oe_o(err_oe));
  // Compare and count
  task automatic check(input logic [24:0] seen, input logic [24:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // Reset with new straps and idle pins; outputs stay low meanwhile
  task automatic do_reset(input logic [1:0] cfg);
    @(negedge clk_i);
    rstn_i = 1'b0;
    {c1, c0} = cfg;
    ctrl_u.last = 25'h0;
    ctrl_u.send(25'h0, 2'h3, 1'b0);
    exp_a = 25'h0;
    hist = 2'h0;
    repeat (10) @(negedge clk_i);
    check(qa | qb, 25'h0);
    check({partial_parity_out, err_oe, ~err_line, ta, ka, sa}, 25'h0);
    rstn_i = 1'b1;
    @(negedge lp);
    @(negedge clk_i);
  endtask : do_reset
  // One link word through the buffer, checked after its capture
  task automatic put(input int i);
    logic [24:0] d;
    logic [1:0]  sn;
    logic [2:0]  side;
    d = WORDS[i];
    sn = SELS[2*i +: 2];
    side = {~d[6], d[10], sn[1]};
    ctrl_u.send(d, sn, FLIPS[i]);
    if (sn != 2'h3) exp_a = d & mask;
    hist = {hist[0], FLIPS[i]};
    @(negedge lp);
    @(negedge clk_i);
    check(qa, exp_a);
    check(qb, c1 ? exp_a : 25'h0);
    check({ta, ka, sa, tb, kb, sb}, {side, c1 ? side : 3'h0});
    check({partial_parity_out, err_oe, err_line}, {FLIPS[i], |hist, ~|hist});
  endtask : put
  // Every strapping, then a closing reset
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    {c1, c0} = 2'h0;
    n_fail = 0;
    checks_done = 0;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1:0]);
      for (int i = 0; i < 7; i++) put(i);
    end
    do_reset(2'h0);
    wrap_up();
  end
  // Cut a hang short
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule : regbuf_top_test
